// File: line_memory_model.sv
// Delay-line command memory and master computer facing the sequencer.
`default_nettype none
module line_memory_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  pulse_count,
  input  wire logic [23:0] cmd_word,
  output logic             command_line_bit,
  output logic             master_top
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] m_cnt_q;
  // The stored command recirculates each word; bit n shows while pulse n is current.
  assign command_line_bit = cmd_word[pulse_count];
  // The master starts out of step so that the slave has to stall to align.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      m_cnt_q <= 5'h0d;
    end else begin
      m_cnt_q <= (m_cnt_q == 5'h17) ? 5'h00 : m_cnt_q + 5'h01;
    end
  end
  assign master_top = m_cnt_q[4];
endmodule // line_memory_model
`default_nettype wire

// File: serial_phase_sequencer.sv
// Timing, sector counting and four-phase command sequencing of a bit-serial machine.
`default_nettype none
// Contract
// RULE1 - Five-stage pulse counter gives 24 pulse times
// RULE2 - Sector carry set at P7 and P15
// RULE3 - Sector carry cleared at P23
// RULE4 - Sector read bit is write bit delayed
// RULE5 - Write bit is read XOR carry unless cleared
// RULE6 - Sector numbers step 000 to 255
// RULE7 - Slave counter stalls while top stages differ
// RULE8 - Master line-37 pulse command zeroes slave sectors
// RULE9 - Two flip-flops encode four phases
// RULE10 - Idle in phase 1, skip unneeded waits
// RULE11 - Bit-five ops skip to phase 4, address-terminated
// RULE12 - Top op-code flip-flop skips phase 1
// RULE13 - Branch condition decides phase 4 or return
// RULE14 - Match flag set P24, cleared on mismatch
// RULE15 - Phase 2 starts on match unless held
// RULE16 - Phase 2 captures command bit 2 at P2
// RULE17 - Bits 4-8 shift operand line selector
// RULE18 - Bits 9-15 shift into op-code register
// RULE19 - Phase 2 P8-P15 stores next-command sector
// RULE20 - Phase 2 P16-P23 stores address sector
// RULE21 - Phase 2 compares address for direct execute
// RULE22 - Phase 2 lasts one sector exactly; re-entered at P2 by a branch return, it lasts 23 pulse times
// RULE23 - Phase 3 waits for address sector match
module serial_phase_sequencer (
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  input  wire logic [3:0]                          address,
  input  wire logic                                read,
  input  wire logic                                write,
  input  wire logic [31:0]                         writedata,
  input  wire logic [3:0]                          byteenable,
  output logic [31:0]                              readdata,
  output logic                                     waitrequest,
  input  wire logic                                command_line_bit,
  input  wire logic                                master_top_in,
  input  wire logic                                slave_clear_in,
  input  wire logic                                branch_cond_in,
  output logic                                     pulse_stage_top,
  output logic [4:0]                               pulse_count,
  output logic                                     sector_read_bit,
  output serial_phase_sequencer_pkg::seq_status_s  seq_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for signals from the other machine.

  logic [1:0] master_top_sync_q;
  logic [1:0] slave_clear_sync_q;
  logic [1:0] branch_sync_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      master_top_sync_q  <= 2'h0;
      slave_clear_sync_q <= 2'h0;
      branch_sync_q      <= 2'h0;
    end else begin
      master_top_sync_q  <= {master_top_sync_q[0], master_top_in};
      slave_clear_sync_q <= {slave_clear_sync_q[0], slave_clear_in};
      branch_sync_q      <= {branch_sync_q[0], branch_cond_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: one wait cycle, then the answer.

  logic [2:0]  ctrl_q, ctrl_d;
  logic        clear_req_q, clear_req_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wait_q, wait_d;
  logic [15:0] sector_shadow_q, sector_shadow_d;
  logic [23:0] ir_q, ir_d;
  serial_phase_sequencer_pkg::seq_status_s st_q, st_d;

  logic req;
  logic hold_sw;
  logic load_switch;
  logic slave_mode;

  assign req         = read | write;
  assign hold_sw     = ctrl_q[serial_phase_sequencer_pkg::CTRL_HOLD];
  assign load_switch = ctrl_q[serial_phase_sequencer_pkg::CTRL_LOAD];
  assign slave_mode  = ctrl_q[serial_phase_sequencer_pkg::CTRL_SLAVE];

  always_comb begin
    wait_d      = ~(req & wait_q);
    ctrl_d      = ctrl_q;
    clear_req_d = 1'b0;
    rdata_d     = rdata_q;
    if (req & wait_q & read) begin
      unique case (address)
        serial_phase_sequencer_pkg::REG_CTRL:   rdata_d = {29'h0, ctrl_q};
        serial_phase_sequencer_pkg::REG_STATUS: rdata_d = {17'h0, st_q};
        serial_phase_sequencer_pkg::REG_SECTOR: rdata_d = {16'h0, sector_shadow_q};
        serial_phase_sequencer_pkg::REG_INSTR:  rdata_d = {8'h0, ir_q};
        default:                                rdata_d = 32'h0;
      endcase
    end
    if (write & ~wait_q & byteenable[0] & (address == serial_phase_sequencer_pkg::REG_CTRL)) begin
      ctrl_d      = writedata[2:0];
      clear_req_d = writedata[serial_phase_sequencer_pkg::CTRL_CLEAR];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_q      <= 1'b1;
      ctrl_q      <= serial_phase_sequencer_pkg::CTRL_RST;
      clear_req_q <= 1'b0;
      rdata_q     <= 32'h0;
    end else begin
      wait_q      <= wait_d;
      ctrl_q      <= ctrl_d;
      clear_req_q <= clear_req_d;
      rdata_q     <= rdata_d;
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse counter.

  logic [4:0] cnt_q, cnt_d;
  logic       pulse_stall;

  function automatic logic in_range(input logic [4:0] c, input logic [4:0] lo, input logic [4:0] hi);
    in_range = (c >= lo) && (c <= hi);
  endfunction

  always_comb begin
    pulse_stall = slave_mode & (cnt_q[4] != master_top_sync_q[1]); // RULE7
    if (pulse_stall) begin
      cnt_d = cnt_q;
    end else if (cnt_q == serial_phase_sequencer_pkg::PULSE_P23) begin
      cnt_d = serial_phase_sequencer_pkg::PULSE_P24; // RULE1
    end else begin
      cnt_d = 5'(cnt_q + 5'h01); // RULE1
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= serial_phase_sequencer_pkg::PULSE_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign pulse_stage_top = cnt_q[4];
  assign pulse_count     = cnt_q;

  logic p24;
  logic sec_lo;
  logic sec_hi;
  // A stalled slave counter repeats a pulse time; word-boundary events must fire once only.
  assign p24    = (cnt_q == serial_phase_sequencer_pkg::PULSE_P24) & ~pulse_stall;
  assign sec_lo = in_range(cnt_q, serial_phase_sequencer_pkg::PULSE_P8, serial_phase_sequencer_pkg::PULSE_P15);
  assign sec_hi = in_range(cnt_q, serial_phase_sequencer_pkg::PULSE_P16, serial_phase_sequencer_pkg::PULSE_P23);

  ////////////////////////////////////////////////////////////////////////////
  // Sector counter: a circulating word incremented on every pass except a clearing pass, which writes it to zero.

  logic                                          sector_carry_ff, sector_carry_d;
  logic                                          sector_write_bit, sector_write_d;
  logic                                          sector_clear_gate, sector_clear_d;
  logic                                          clear_pend_q, clear_pend_d;
  logic [serial_phase_sequencer_pkg::SECTOR_DELAY-1:0] sector_dly_q;
  logic                                          sector_read_q;

  always_comb begin
    clear_pend_d   = clear_pend_q | slave_clear_sync_q[1] | clear_req_q; // RULE8
    sector_clear_d = sector_clear_gate;
    if (p24) begin
      sector_clear_d = clear_pend_d;
      clear_pend_d   = 1'b0;
    end
    if (cnt_q == serial_phase_sequencer_pkg::PULSE_P23) begin
      sector_carry_d = 1'b0; // RULE3
    end else if ((cnt_q == serial_phase_sequencer_pkg::PULSE_P7) ||
                 (cnt_q == serial_phase_sequencer_pkg::PULSE_P15)) begin
      sector_carry_d = 1'b1; // RULE2
    end else if (!sector_read_q) begin
      sector_carry_d = 1'b0;
    end else begin
      sector_carry_d = sector_carry_ff;
    end
    sector_write_d = (sector_read_q ^ sector_carry_ff) & ~sector_clear_gate; // RULE5
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sector_carry_ff   <= 1'b0;
      sector_write_bit  <= 1'b0;
      sector_clear_gate <= 1'b0;
      clear_pend_q      <= 1'b0;
      sector_dly_q      <= '0;
      sector_read_q     <= 1'b0;
    end else begin
      sector_carry_ff   <= sector_carry_d;
      sector_write_bit  <= sector_write_d;
      sector_clear_gate <= sector_clear_d;
      clear_pend_q      <= clear_pend_d;
      sector_dly_q      <= {sector_dly_q[serial_phase_sequencer_pkg::SECTOR_DELAY-2:0], sector_write_bit}; // RULE4
      sector_read_q     <= sector_dly_q[serial_phase_sequencer_pkg::SECTOR_DELAY-1]; // RULE4
    end
  end

  assign sector_read_bit = sector_read_q;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register, op-code register, line selector and phases.

  logic opcode_bit_five;
  logic opcode_bit_two;
  logic phase1;
  logic phase2;
  logic phase3;
  logic phase4;
  logic line_load_gate;
  logic opcode_shift_gate;
  logic instr_reg_read_bit;
  logic instr_reg_write_bit;
  logic branch_op;
  logic two_sector_op;
  logic end_exec;
  logic compare_en;

  assign opcode_bit_five = st_q.opcode[4];
  assign opcode_bit_two  = st_q.opcode[1];
  assign phase1 = ~st_q.phase_bit_high & ~st_q.phase_bit_low; // RULE9
  assign phase2 = ~st_q.phase_bit_high &  st_q.phase_bit_low; // RULE9
  assign phase3 =  st_q.phase_bit_high &  st_q.phase_bit_low; // RULE9
  assign phase4 =  st_q.phase_bit_high & ~st_q.phase_bit_low; // RULE9
  assign line_load_gate    = phase2 & ~pulse_stall & in_range(cnt_q, serial_phase_sequencer_pkg::PULSE_P4,
                                               serial_phase_sequencer_pkg::PULSE_P8);
  assign opcode_shift_gate = phase2 & ~pulse_stall & in_range(cnt_q, serial_phase_sequencer_pkg::PULSE_P9,
                                               serial_phase_sequencer_pkg::PULSE_P15);
  assign instr_reg_read_bit = ir_q[cnt_q];
  assign branch_op     = st_q.opcode[4] & st_q.opcode[3] & st_q.opcode[2];
  assign two_sector_op = ~st_q.opcode[5] & ~st_q.opcode[4] & st_q.opcode[0] &
                         (st_q.opcode[1] | st_q.opcode[2]);

  always_comb begin
    instr_reg_write_bit = instr_reg_read_bit;
    if (phase2 & sec_lo) begin
      instr_reg_write_bit = sector_read_q; // RULE19
    end else if (phase2 & sec_hi) begin
      instr_reg_write_bit = command_line_bit; // RULE20
    end else if (phase4 & st_q.opcode_top_ff & sec_lo) begin
      instr_reg_write_bit = sector_read_q; // RULE12
    end
    compare_en = (phase1 & sec_lo) |                          // RULE14
                 (st_q.phase_bit_low & ~opcode_bit_five & sec_hi) | // RULE21 RULE23
                 (phase4 & opcode_bit_five & sec_hi) |        // RULE11
                 (phase4 & ~opcode_bit_five & sec_lo);
    end_exec = phase4 & p24 & ((~opcode_bit_five & ~two_sector_op) |
                               (opcode_bit_five & st_q.sector_match_ff)); // RULE11
  end

  always_comb begin
    st_d            = st_q;
    ir_d            = ir_q;
    sector_shadow_d = sector_shadow_q;
    ir_d[cnt_q]     = instr_reg_write_bit;
    if (sec_lo) begin
      sector_shadow_d[7:0] = {sector_read_q, sector_shadow_q[7:1]}; // RULE6
    end
    if (sec_hi) begin
      sector_shadow_d[15:8] = {sector_read_q, sector_shadow_q[15:9]}; // RULE6
    end
    if (p24) begin
      st_d.sector_match_ff = 1'b1; // RULE14
    end else if (compare_en & (sector_read_q != instr_reg_write_bit)) begin
      st_d.sector_match_ff = 1'b0; // RULE14
    end
    if (phase2 & (cnt_q == serial_phase_sequencer_pkg::PULSE_P2)) begin
      st_d.opcode[1] = command_line_bit; // RULE16
    end
    if (line_load_gate) begin
      st_d.line_sel = {(opcode_bit_two ? instr_reg_read_bit : command_line_bit),
                       st_q.line_sel[4:1]}; // RULE17
    end
    if (opcode_shift_gate) begin
      st_d.opcode_top_ff = command_line_bit; // RULE18
      st_d.opcode        = {st_q.opcode_top_ff, st_q.opcode[5:1]}; // RULE18
    end
    if (phase2 & (cnt_q == serial_phase_sequencer_pkg::PULSE_P23) & branch_op & branch_sync_q[1]) begin
      st_d.opcode_top_ff = 1'b1; // RULE13
    end
    unique case ({st_q.phase_bit_high, st_q.phase_bit_low})
      2'b00: begin
        if (p24 & st_q.sector_match_ff & ~hold_sw & ~load_switch) begin
          st_d.phase_bit_low = 1'b1; // RULE15 RULE10
        end
      end
      2'b01: begin
        if (p24) begin
          st_d.phase_bit_high = 1'b1; // RULE22
          if (st_q.sector_match_ff) begin
            st_d.phase_bit_low = 1'b0; // RULE21 RULE10
          end
        end
      end
      2'b11: begin
        if (p24 & st_q.sector_match_ff) begin
          st_d.phase_bit_low = 1'b0; // RULE23
        end
      end
      2'b10: begin
        if (branch_op & ~st_q.opcode_top_ff) begin
          st_d.phase_bit_high = 1'b0; // RULE13
          st_d.phase_bit_low  = 1'b1; // RULE13
        end else if (end_exec) begin
          st_d.phase_bit_high = 1'b0;
          st_d.opcode_top_ff  = 1'b0;
          st_d.phase_bit_low  = ~hold_sw & ~load_switch &
                                (st_q.opcode_top_ff | (~opcode_bit_five & st_q.sector_match_ff)); // RULE12 RULE10
        end else if (p24 & two_sector_op) begin
          st_d.opcode[1] = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q            <= serial_phase_sequencer_pkg::STATUS_RST;
      ir_q            <= 24'h0;
      sector_shadow_q <= 16'h0;
    end else begin
      st_q            <= st_d;
      ir_q            <= ir_d;
      sector_shadow_q <= sector_shadow_d;
    end
  end

  assign seq_status = st_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence s_branch_miss;
    phase4 & branch_op & ~st_q.opcode_top_ff;
  endsequence

  sequence s_phase1_go;
    phase1 & p24 & st_q.sector_match_ff & ~hold_sw & ~load_switch;
  endsequence

  AST_PULSE_WRAP: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    (cnt_q == serial_phase_sequencer_pkg::PULSE_P23) & ~pulse_stall |=> p24)
    else $error("pulse counter did not wrap after P23");

  AST_PULSE_RANGE: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
    cnt_q <= serial_phase_sequencer_pkg::PULSE_P23)
    else $error("pulse counter left its 24 counts");

  AST_CARRY_P15: assert property (@(posedge ref_clk) disable iff (rst) // RULE2
    (cnt_q == serial_phase_sequencer_pkg::PULSE_P15) |=> sector_carry_ff)
    else $error("sector carry not set after P15");

  AST_CARRY_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
    (cnt_q == serial_phase_sequencer_pkg::PULSE_P23) |=> ~sector_carry_ff)
    else $error("sector carry not cleared after P23");

  AST_LOOP_DELAY: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
    ##23 1 |-> sector_read_q == $past(sector_write_bit, 23))
    else $error("sector read bit is not the delayed write bit");

  AST_CLEAR_ZERO: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
    sector_clear_gate |=> ~sector_write_bit)
    else $error("sector write bit not zero while cleared");

  AST_SLAVE_STALL: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
    pulse_stall |=> $stable(cnt_q))
    else $error("slave counter advanced while top stages differ");

  AST_MATCH_SET: assert property (@(posedge ref_clk) disable iff (rst) // RULE14
    p24 |=> st_q.sector_match_ff)
    else $error("match flag not set at P24");

  AST_PH2_ENTRY: assert property (@(posedge ref_clk) disable iff (rst) // RULE15
    s_phase1_go |=> phase2)
    else $error("phase 2 not entered on match");

  AST_HOLD_BLOCK: assert property (@(posedge ref_clk) disable iff (rst) // RULE15
    phase1 & (hold_sw | load_switch) |=> ~st_q.phase_bit_low)
    else $error("phase 2 entered while held");

  AST_BIT2_CAPTURE: assert property (@(posedge ref_clk) disable iff (rst) // RULE16
    phase2 & (cnt_q == serial_phase_sequencer_pkg::PULSE_P2) |=> st_q.opcode[1] == $past(command_line_bit))
    else $error("command bit 2 not captured");

  AST_PH2_ONE_SECTOR: assert property (@(posedge ref_clk) disable iff (rst) // RULE22
    phase2 & p24 |=> st_q.phase_bit_high ##23 st_q.phase_bit_high | phase2)
    else $error("phase 2 did not end after one sector");

  AST_O5_SKIP: assert property (@(posedge ref_clk) disable iff (rst) // RULE11
    phase2 & p24 & opcode_bit_five |=> phase4)
    else $error("bit-five command did not go to phase 4");

  AST_BRANCH_RETURN: assert property (@(posedge ref_clk) disable iff (rst) // RULE13
    s_branch_miss |=> phase2)
    else $error("untaken branch did not return to phase 2");

endmodule : serial_phase_sequencer
`default_nettype wire

// File: serial_phase_sequencer_bench.sv
// Self-checking bench of the serial phase sequencer.
`default_nettype none
module serial_phase_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst, read, write, slave_clear_in, branch_cond_in;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, q, rnd;
  logic        waitrequest, command_line_bit, master_top_in, pulse_stage_top, sector_read_bit;
  logic [4:0]  pulse_count, ln;
  logic [23:0] cmd_word;
  logic [7:0]  lo, hi, l0, h0, ad;
  logic [5:0]  op;
  int          mismatches, n_tests, words, w0, w1;
  serial_phase_sequencer_pkg::seq_status_s seq_status;
  serial_phase_sequencer i_dut (
    .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .command_line_bit(command_line_bit), .master_top_in(master_top_in), .slave_clear_in(slave_clear_in),
    .branch_cond_in(branch_cond_in), .pulse_stage_top(pulse_stage_top), .pulse_count(pulse_count),
    .sector_read_bit(sector_read_bit), .seq_status(seq_status));
  line_memory_model i_mem (
    .ref_clk(ref_clk), .rst(rst), .pulse_count(pulse_count), .cmd_word(cmd_word),
    .command_line_bit(command_line_bit), .master_top(master_top_in));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (pulse_count === 5'h00) words <= words + 1;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [4:0] nxt(input logic [4:0] p);
    return (p == 5'h17) ? 5'h00 : p + 5'h01;
  endfunction
  // Command layout: address sector, top op bit, op code, line field, then low bits clear.
  function automatic logic [23:0] mk(input logic [5:0] o, input logic c, input logic [4:0] l, input logic [7:0] a);
    return {a, c, o, l, 4'h0};
  endfunction
  function automatic logic [1:0] ph();
    return {seq_status.phase_bit_high, seq_status.phase_bit_low};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    k = 0;
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= !wr;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0 && k < 20) begin
      @(posedge ref_clk);
      k++;
    end
    chk("waitrequest", 0, waitrequest);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic cnt(input int k);
    logic [4:0] p;
    p = pulse_count;
    repeat (k) begin
      @(posedge ref_clk);
      chk("pulse step", nxt(p), pulse_count);
      chk("top stage", pulse_count[4], pulse_stage_top);
      p = pulse_count;
    end
  endtask
  task automatic rsec(output int w);
    while (pulse_count !== 5'h01) @(posedge ref_clk);
    w = words;
    bus(0, serial_phase_sequencer_pkg::REG_SECTOR, 0, 4'hf);
    lo = q[7:0];
    hi = q[15:8];
  endtask
  task automatic wph(input logic [1:0] p, input int lim);
    int k;
    k = 0;
    while (ph() !== p && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
    chk("phase reached", p, ph());
  endtask
  task automatic ph2(input int lim, input int len);
    int k;
    k = 0;
    wph(2'b01, lim);
    while (ph() === 2'b01 && k < 40) begin
      @(posedge ref_clk);
      k++;
    end
    chk("read phase length", len, k);
  endtask
  task automatic watch(input int k);
    int bad;
    bad = 0;
    repeat (k) begin
      @(posedge ref_clk);
      if (ph() !== 2'b00) bad++;
    end
    chk("held in wait phase", 0, bad);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    ref_clk = 0;
    rst = 1;
    read = 0;
    write = 0;
    address = 0;
    writedata = 0;
    byteenable = 4'hf;
    slave_clear_in = 0;
    branch_cond_in = 0;
    cmd_word = mk(6'o35, 1'b0, 5'h00, 8'h00);
    mismatches = 0;
    n_tests = 0;
    words = 0;
    rnd = 32'h1232;
    repeat (5) @(posedge ref_clk);
    chk("reset waitrequest", 1, waitrequest);
    chk("reset pulse", 0, pulse_count);
    chk("reset status", 0, seq_status);
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    bus(0, serial_phase_sequencer_pkg::REG_CTRL, 0, 4'hf);
    chk("ctrl reset", 0, q);
    bus(1, serial_phase_sequencer_pkg::REG_CTRL, 32'h1, 4'hf);
    cnt(48);
    bus(0, 4'h2, 0, 4'hf);
    chk("unmapped read", 0, q);
    bus(1, serial_phase_sequencer_pkg::REG_CTRL, 32'h0, 4'h0);
    rsec(w0);
    l0 = lo;
    h0 = hi;
    repeat (120) @(posedge ref_clk);
    rsec(w1);
    chk("low sector step", 8'(l0 + 8'(w1 - w0)), lo);
    chk("high sector step", 8'(h0 + 8'(w1 - w0)), hi);
    watch(6240);
    bus(1, serial_phase_sequencer_pkg::REG_CTRL, 32'h2, 4'hf);
    watch(6240);
    bus(1, serial_phase_sequencer_pkg::REG_CTRL, 32'h9, 4'hf);
    bus(0, serial_phase_sequencer_pkg::REG_CTRL, 0, 4'hf);
    chk("ctrl after clear", 1, q);
    repeat (72) @(posedge ref_clk);
    rsec(w0);
    chk("sector after clear", 1, lo < 8'h04 && lo == hi);
    bus(1, serial_phase_sequencer_pkg::REG_CTRL, 32'h0, 4'hf);
    ph2(7000, 24);
    wph(2'b10, 3);
    chk("branch op", 6'o35, seq_status.opcode);
    chk("branch top", 0, seq_status.opcode_top_ff);
    rnd = xs(rnd);
    op = 6'o20 + 6'(rnd[3:0] % 4'd12);
    ln = rnd[8:4];
    ad = rnd[16:9];
    cmd_word <= mk(op, 1'b0, ln, ad);
    wph(2'b01, 3);
    ph2(30, 23);
    chk("skip to execute", 2'b10, ph());
    chk("op code", op, seq_status.opcode);
    chk("line select", ln, seq_status.line_sel);
    bus(0, serial_phase_sequencer_pkg::REG_INSTR, 0, 4'hf);
    chk("address sector", ad, q[23:16]);
    wph(2'b00, 6300);
    rnd = xs(rnd);
    cmd_word <= mk(6'o01, 1'b1, rnd[4:0], rnd[12:5]);
    ph2(6300, 24);
    chk("after read phase", 1, seq_status.phase_bit_high);
    wph(2'b10, 6300);
    w0 = 0;
    while (ph() === 2'b10 && w0 < 60) begin
      @(posedge ref_clk);
      w0++;
    end
    chk("top op skips wait", 2'b01, ph());
    bus(1, serial_phase_sequencer_pkg::REG_CTRL, 32'h4, 4'hf);
    repeat (300) @(posedge ref_clk);
    cnt(24);
    slave_clear_in <= 1'b1;
    repeat (30) @(posedge ref_clk);
    slave_clear_in <= 1'b0;
    repeat (72) @(posedge ref_clk);
    rsec(w0);
    chk("slave sector zeroed", 1, lo < 8'h04 && lo == hi);
    print_verdict();
  end
endmodule // serial_phase_sequencer_bench
`default_nettype wire

// File: serial_phase_sequencer_pkg.sv
// Constants and carrier types shared by the serial phase sequencer.
`default_nettype none
package serial_phase_sequencer_pkg;

  // Pulse counter codes: P1..P23 are 1..23, P24 is 0.
  localparam logic [4:0] PULSE_P24  = 5'h00;
  localparam logic [4:0] PULSE_P2   = 5'h02;
  localparam logic [4:0] PULSE_P4   = 5'h04;
  localparam logic [4:0] PULSE_P7   = 5'h07;
  localparam logic [4:0] PULSE_P8   = 5'h08;
  localparam logic [4:0] PULSE_P9   = 5'h09;
  localparam logic [4:0] PULSE_P15  = 5'h0f;
  localparam logic [4:0] PULSE_P16  = 5'h10;
  localparam logic [4:0] PULSE_P23  = 5'h17;
  localparam logic [4:0] PULSE_RST  = 5'h00;

  // Delay stages between sector write and read flip-flops.
  localparam int unsigned SECTOR_DELAY = 22;
  localparam int unsigned WORD_BITS    = 24;

  // Register byte offsets.
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SECTOR = 4'h8;
  localparam logic [3:0] REG_INSTR  = 4'hc;

  // Control register fields and reset value.
  localparam int unsigned CTRL_HOLD  = 0;
  localparam int unsigned CTRL_LOAD  = 1;
  localparam int unsigned CTRL_SLAVE = 2;
  localparam int unsigned CTRL_CLEAR = 3;
  localparam logic [2:0]  CTRL_RST   = 3'h0;

  typedef struct packed {
    logic       phase_bit_high;
    logic       phase_bit_low;
    logic       sector_match_ff;
    logic       opcode_top_ff;
    logic [5:0] opcode;
    logic [4:0] line_sel;
  } seq_status_s;

  localparam seq_status_s STATUS_RST = '0;

endpackage : serial_phase_sequencer_pkg
`default_nettype wire
